/* rapc_map.vh */
// Constants for the region attribute and permission checker
`ifndef RAPC_MAP_VH
`define RAPC_MAP_VH

// Region count and attribute word layout
`define RAPC_REGIONS 8
`define RAPC_ATTR_W 11
`define RAPC_BIT_B 0
`define RAPC_BIT_C 1
`define RAPC_BIT_S 2
`define RAPC_TYPE_LO 3
`define RAPC_TYPE_HI 5
`define RAPC_PERM_LO 6
`define RAPC_PERM_HI 8
`define RAPC_BIT_NOEXEC 9
`define RAPC_BIT_EN 10
`define RAPC_ATTR_RESET 11'h000

// Access permission codes
`define RAPC_PERM_NONE 3'h0
`define RAPC_PERM_PRIV_RW 3'h1
`define RAPC_PERM_USER_RO 3'h2
`define RAPC_PERM_FULL 3'h3
`define RAPC_PERM_RSVD 3'h4
`define RAPC_PERM_PRIV_RO 3'h5
`define RAPC_PERM_RO_A 3'h6
`define RAPC_PERM_RO_B 3'h7

// Memory type codes
`define RAPC_MT_STRONG 2'h0
`define RAPC_MT_DEVICE 2'h1
`define RAPC_MT_NORMAL 2'h2
`define RAPC_MT_RSVD 2'h3

// Cache policy codes
`define RAPC_POL_NC 2'h0
`define RAPC_POL_WB_RWA 2'h1
`define RAPC_POL_WT 2'h2
`define RAPC_POL_WB_NWA 2'h3

// Fault cause bits
`define RAPC_CAUSE_W 8
`define RAPC_CAUSE_IACC 0
`define RAPC_CAUSE_DACC 1
`define RAPC_CAUSE_RESET 8'h00

`endif

/* rapc_attr_decode.v */
// Memory type and cache policy decoder for one attribute set
`timescale 1ns/1ns
`default_nettype none
`include "rapc_map.vh"

module rapc_attr_decode (
    input wire [2:0] type_extension_field,
    input wire share_bit,
    input wire cache_bit,
    input wire buffer_bit,
    output reg [1:0] mem_type,
    output reg shareable,
    output reg [1:0] inner_cache_policy,
    output reg [1:0] outer_cache_policy
);

    always @* begin
        mem_type = `RAPC_MT_RSVD;
        shareable = 1'b0;
        inner_cache_policy = `RAPC_POL_NC;
        outer_cache_policy = `RAPC_POL_NC;
        if (type_extension_field[2]) begin
            mem_type = `RAPC_MT_NORMAL;
            shareable = share_bit;
            outer_cache_policy = type_extension_field[1:0];
            inner_cache_policy = {cache_bit, buffer_bit};
        end else begin
            case (type_extension_field[1:0])
                2'h0: begin
                    if (!cache_bit) begin
                        mem_type = buffer_bit ? `RAPC_MT_DEVICE : `RAPC_MT_STRONG;
                        shareable = 1'b1;
                    end else begin
                        mem_type = `RAPC_MT_NORMAL;
                        shareable = share_bit;
                        inner_cache_policy = `RAPC_POL_WT;
                        outer_cache_policy = `RAPC_POL_WT;
                    end
                end
                2'h1: begin
                    if (cache_bit == buffer_bit) begin
                        mem_type = `RAPC_MT_NORMAL;
                        shareable = share_bit;
                        if (cache_bit) begin
                            inner_cache_policy = `RAPC_POL_WB_RWA;
                            outer_cache_policy = `RAPC_POL_WB_RWA;
                        end
                    end
                end
                2'h2: begin
                    if (!cache_bit && !buffer_bit) begin
                        mem_type = `RAPC_MT_DEVICE;
                    end
                end
                default: begin
                    mem_type = `RAPC_MT_RSVD;
                end
            endcase
        end
    end

endmodule // rapc_attr_decode

`default_nettype wire

/* rapc_check.v */
// Region attribute store, region selection and permission checker
`timescale 1ns/1ns
`default_nettype none
`include "rapc_map.vh"

module rapc_check (
    input wire ref_clk,
    input wire rst,
    input wire mpu_enable,
    input wire background_enable,
    input wire attr_wr_en,
    input wire [2:0] attr_wr_region,
    input wire [10:0] attr_wr_data,
    input wire [2:0] attr_rd_region,
    output reg [10:0] region_attribute_size_reg,
    input wire acc_valid,
    input wire [31:0] acc_addr,
    input wire acc_priv,
    input wire acc_write,
    input wire acc_fetch,
    input wire [7:0] acc_region_hit,
    output reg acc_done,
    output reg acc_grant,
    output reg acc_fault,
    output reg memmanage_fault_exc,
    output reg [1:0] acc_mem_type,
    output reg acc_shareable,
    output reg [1:0] inner_cache_policy,
    output reg [1:0] outer_cache_policy,
    output reg acc_region_valid,
    output reg [2:0] acc_region_num,
    input wire [7:0] cause_clear,
    output reg [7:0] memmanage_fault_cause_reg,
    output reg [31:0] fault_addr
);

    // Attribute store, one word per region
    reg [10:0] attr_mem [0:7];
    integer i;
    integer j;

    // Region selection results
    reg sel_hit;
    reg [2:0] sel_num;
    reg [10:0] sel_attr;

    // Fields of the selected region
    wire [2:0] type_extension_field;
    wire [2:0] access_permission_field;
    wire execute_never_flag;
    assign type_extension_field = sel_attr[`RAPC_TYPE_HI:`RAPC_TYPE_LO];
    assign access_permission_field = sel_attr[`RAPC_PERM_HI:`RAPC_PERM_LO];
    assign execute_never_flag = sel_attr[`RAPC_BIT_NOEXEC];

    // Decoded region attributes
    wire [1:0] reg_mem_type;
    wire reg_shareable;
    wire [1:0] reg_inner;
    wire [1:0] reg_outer;

    rapc_attr_decode u_decode (
        .type_extension_field(type_extension_field),
        .share_bit(sel_attr[`RAPC_BIT_S]),
        .cache_bit(sel_attr[`RAPC_BIT_C]),
        .buffer_bit(sel_attr[`RAPC_BIT_B]),
        .mem_type(reg_mem_type),
        .shareable(reg_shareable),
        .inner_cache_policy(reg_inner),
        .outer_cache_policy(reg_outer)
    );

    // Default map attributes by address
    reg [1:0] dflt_mem_type;
    reg dflt_shareable;
    reg [1:0] dflt_policy;
    reg dflt_noexec;

    // Check results
    reg perm_ok;
    reg fault_now;
    reg [1:0] next_mem_type;
    reg next_shareable;
    reg [1:0] next_inner;
    reg [1:0] next_outer;
    reg [7:0] next_cause;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < `RAPC_REGIONS; i = i + 1) begin
                attr_mem[i] <= `RAPC_ATTR_RESET;
            end
        end else if (attr_wr_en) begin
            attr_mem[attr_wr_region] <= attr_wr_data;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            region_attribute_size_reg <= `RAPC_ATTR_RESET;
        end else begin
            region_attribute_size_reg <= attr_mem[attr_rd_region];
        end
    end

    always @* begin
        sel_hit = 1'b0;
        sel_num = 3'h0;
        for (j = 0; j < `RAPC_REGIONS; j = j + 1) begin
            if (acc_region_hit[j] && attr_mem[j][`RAPC_BIT_EN]) begin
                sel_hit = 1'b1;
                sel_num = j[2:0];
            end
        end
        sel_attr = attr_mem[sel_num];
    end

    // Fixed default map, top three address bits
    always @* begin
        dflt_mem_type = `RAPC_MT_NORMAL;
        dflt_shareable = 1'b0;
        dflt_policy = `RAPC_POL_WT;
        dflt_noexec = 1'b0;
        case (acc_addr[31:29])
            3'h0: begin
                dflt_policy = `RAPC_POL_WT;
            end
            3'h1: begin
                dflt_policy = `RAPC_POL_WB_RWA;
            end
            3'h2: begin
                dflt_mem_type = `RAPC_MT_DEVICE;
                dflt_shareable = 1'b1;
                dflt_policy = `RAPC_POL_NC;
                dflt_noexec = 1'b1;
            end
            3'h3: begin
                dflt_policy = `RAPC_POL_WB_RWA;
            end
            3'h4: begin
                dflt_policy = `RAPC_POL_WT;
            end
            3'h5, 3'h6: begin
                dflt_mem_type = `RAPC_MT_DEVICE;
                dflt_shareable = acc_addr[29] ? 1'b1 : 1'b0;
                dflt_policy = `RAPC_POL_NC;
                dflt_noexec = 1'b1;
            end
            default: begin
                // System space is strongly ordered and never executable
                dflt_mem_type = `RAPC_MT_STRONG;
                dflt_shareable = 1'b1;
                dflt_policy = `RAPC_POL_NC;
                dflt_noexec = 1'b1;
            end
        endcase
    end

    always @* begin
        perm_ok = 1'b0;
        case (access_permission_field)
            `RAPC_PERM_NONE: begin
                perm_ok = 1'b0;
            end
            `RAPC_PERM_PRIV_RW: begin
                perm_ok = acc_priv;
            end
            `RAPC_PERM_USER_RO: begin
                perm_ok = acc_priv | ~acc_write;
            end
            `RAPC_PERM_FULL: begin
                perm_ok = 1'b1;
            end
            `RAPC_PERM_PRIV_RO: begin
                perm_ok = acc_priv & ~acc_write;
            end
            `RAPC_PERM_RO_A, `RAPC_PERM_RO_B: begin
                perm_ok = ~acc_write;
            end
            default: begin
                perm_ok = 1'b0;
            end
        endcase
    end

    // Fault and attribute selection for the current access
    always @* begin
        fault_now = 1'b0;
        next_mem_type = dflt_mem_type;
        next_shareable = dflt_shareable;
        next_inner = dflt_policy;
        next_outer = dflt_policy;
        next_cause = 8'h00;
        if (!mpu_enable) begin
            // Protection off: default map, only its execute-never applies
            fault_now = acc_fetch & dflt_noexec;
        end else if (sel_hit) begin
            next_mem_type = reg_mem_type;
            next_shareable = reg_shareable;
            next_inner = reg_inner;
            next_outer = reg_outer;
            fault_now = ~perm_ok | (acc_fetch & (execute_never_flag | dflt_noexec));
        end else begin
            fault_now = ~(background_enable & acc_priv) | (acc_fetch & dflt_noexec);
        end
        if (fault_now) begin
            if (acc_fetch) begin
                next_cause[`RAPC_CAUSE_IACC] = 1'b1;
            end else begin
                next_cause[`RAPC_CAUSE_DACC] = 1'b1;
            end
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_done <= 1'b0;
            acc_grant <= 1'b0;
            acc_fault <= 1'b0;
            memmanage_fault_exc <= 1'b0;
        end else begin
            acc_done <= acc_valid;
            acc_grant <= acc_valid & ~fault_now;
            acc_fault <= acc_valid & fault_now;
            memmanage_fault_exc <= acc_valid & fault_now;
        end
    end

    // Attributes of the last access, held until the next one
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_mem_type <= `RAPC_MT_STRONG;
            acc_shareable <= 1'b0;
            inner_cache_policy <= `RAPC_POL_NC;
            outer_cache_policy <= `RAPC_POL_NC;
            acc_region_valid <= 1'b0;
            acc_region_num <= 3'h0;
        end else if (acc_valid) begin
            acc_mem_type <= next_mem_type;
            acc_shareable <= next_shareable;
            inner_cache_policy <= next_inner;
            outer_cache_policy <= next_outer;
            acc_region_valid <= mpu_enable & sel_hit;
            acc_region_num <= sel_num;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            memmanage_fault_cause_reg <= `RAPC_CAUSE_RESET;
        end else if (acc_valid) begin
            memmanage_fault_cause_reg <= (memmanage_fault_cause_reg & ~cause_clear) | next_cause;
        end else begin
            memmanage_fault_cause_reg <= memmanage_fault_cause_reg & ~cause_clear;
        end
    end

    // Faulting address of the latest violation
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fault_addr <= 32'h0000_0000;
        end else if (acc_valid && fault_now) begin
            fault_addr <= acc_addr;
        end
    end

endmodule // rapc_check

`default_nettype wire

/* rapc_props.sv */
// Assertion checker for the region attribute and permission checker
`timescale 1ns/1ns
`default_nettype none
module rapc_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic acc_fetch,
    input wire logic acc_done,
    input wire logic acc_grant,
    input wire logic acc_fault,
    input wire logic memmanage_fault_exc,
    input wire logic [7:0] cause_clear,
    input wire logic [7:0] memmanage_fault_cause_reg,
    input wire logic [31:0] fault_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_answer;
        acc_valid |=> acc_done;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");

    property p_quiet;
        !acc_valid |=> !acc_done;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");

    property p_one;
        acc_done |-> (acc_grant ^ acc_fault);
    endproperty
    a_one: assert property (p_one) else $error("grant and fault disagree");

    property p_exc;
        memmanage_fault_exc == acc_fault;
    endproperty
    a_exc: assert property (p_exc) else $error("exception not with fault");

    property p_data_cause;
        acc_valid && !acc_fetch ##1 acc_fault |-> memmanage_fault_cause_reg[1];
    endproperty
    a_data_cause: assert property (p_data_cause) else $error("data cause missing");

    property p_instr_cause;
        acc_valid && acc_fetch ##1 acc_fault |-> memmanage_fault_cause_reg[0];
    endproperty
    a_instr_cause: assert property (p_instr_cause) else $error("fetch cause missing");

    property p_addr;
        acc_valid ##1 acc_fault |-> fault_addr == $past(acc_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("fault address wrong");

    // Fetch cause bit 0 must stay until software clears it
    property p_sticky;
        memmanage_fault_cause_reg[0] && !cause_clear[0] |=> memmanage_fault_cause_reg[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("cause lost");

    property p_clear;
        cause_clear[1] && !acc_valid |=> !memmanage_fault_cause_reg[1];
    endproperty
    a_clear: assert property (p_clear) else $error("cause not cleared");
endmodule // rapc_props

bind rapc_check rapc_props props (.ref_clk, .rst, .acc_valid, .acc_addr, .acc_fetch, .acc_done,
    .acc_grant, .acc_fault, .memmanage_fault_exc, .cause_clear, .memmanage_fault_cause_reg,
    .fault_addr);
`default_nettype wire

/* rapc_core_model.sv */
// Model of the core load, store and fetch path
`timescale 1ns/1ns
`default_nettype none
module rapc_core_model (
    input wire logic ref_clk,
    output logic acc_valid,
    output logic [31:0] acc_addr,
    output logic acc_priv,
    output logic acc_write,
    output logic acc_fetch,
    output logic [7:0] acc_region_hit,
    input wire logic acc_done,
    input wire logic acc_grant,
    input wire logic acc_fault
);
    initial begin
        acc_valid = 1'b0;
        acc_addr = 32'h0000_0000;
        acc_priv = 1'b0;
        acc_write = 1'b0;
        acc_fetch = 1'b0;
        acc_region_hit = 8'h00;
    end

    // Answer is registered on the taking edge and read just after it
    task automatic access(input logic [31:0] a, input logic p, w, f, input logic [7:0] h,
        output logic ok);
        @(posedge ref_clk);
        #1;
        acc_valid = 1'b1;
        acc_addr = a;
        acc_priv = p;
        acc_write = w;
        acc_fetch = f;
        acc_region_hit = h;
        @(posedge ref_clk);
        #1;
        acc_valid = 1'b0;
        // Released address and hit lines show junk so stale values cannot help
        acc_addr = ~a;
        acc_region_hit = ~h;
        ok = acc_done ? (acc_grant & !acc_fault) : 1'bx;
    endtask
endmodule // rapc_core_model
`default_nettype wire

/* tb_rapc_check.sv */
// Testbench for the region attribute and permission checker
`timescale 1ns/1ns
`default_nettype none
module tb_rapc_check;
    logic ref_clk, rst, mpu_enable, background_enable, attr_wr_en, ok;
    logic [2:0] attr_wr_region, attr_rd_region, acc_region_num;
    logic [10:0] attr_wr_data, region_attribute_size_reg;
    logic acc_valid, acc_priv, acc_write, acc_fetch, acc_done, acc_grant, acc_fault;
    logic memmanage_fault_exc, acc_shareable, acc_region_valid;
    logic [31:0] acc_addr, fault_addr;
    logic [7:0] acc_region_hit, cause_clear, memmanage_fault_cause_reg;
    logic [1:0] acc_mem_type, inner_cache_policy, outer_cache_policy;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // Allowed bit per {permission, privileged, write}
    logic [31:0] perm_ok = 32'h5540_fdc0;
    // {extension, S C B, type, shareable, inner, outer}
    logic [12:0] dec_tab [0:11] = '{{3'h0, 3'h0, 2'h0, 1'h1, 4'h0}, {3'h0, 3'h5, 2'h1, 1'h1, 4'h0},
        {3'h0, 3'h2, 2'h2, 1'h0, 4'ha}, {3'h0, 3'h7, 2'h2, 1'h1, 4'ha}, {3'h1, 3'h7, 2'h2, 1'h1, 4'h5},
        {3'h1, 3'h0, 2'h2, 1'h0, 4'h0}, {3'h2, 3'h4, 2'h1, 1'h0, 4'h0}, {3'h6, 3'h5, 2'h2, 1'h1, 4'h6},
        {3'h7, 3'h3, 2'h2, 1'h0, 4'hf}, {3'h5, 3'h2, 2'h2, 1'h0, 4'h9}, {3'h4, 3'h0, 2'h2, 1'h0, 4'h0},
        {3'h0, 3'h6, 2'h2, 1'h1, 4'ha}};

    rapc_check dut (.ref_clk, .rst, .mpu_enable, .background_enable, .attr_wr_en, .attr_wr_region,
        .attr_wr_data, .attr_rd_region, .region_attribute_size_reg, .acc_valid, .acc_addr, .acc_priv,
        .acc_write, .acc_fetch, .acc_region_hit, .acc_done, .acc_grant, .acc_fault,
        .memmanage_fault_exc, .acc_mem_type, .acc_shareable, .inner_cache_policy,
        .outer_cache_policy, .acc_region_valid, .acc_region_num, .cause_clear,
        .memmanage_fault_cause_reg, .fault_addr);
    rapc_core_model core (.ref_clk, .acc_valid, .acc_addr, .acc_priv, .acc_write, .acc_fetch,
        .acc_region_hit, .acc_done, .acc_grant, .acc_fault);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_attr(input logic [2:0] r, input logic [10:0] w);
        @(posedge ref_clk);
        #1;
        attr_wr_en = 1'b1;
        attr_wr_region = r;
        attr_rd_region = r;
        attr_wr_data = w;
        @(posedge ref_clk);
        #1;
        attr_wr_en = 1'b0;
        attr_wr_data = ~w;
        @(posedge ref_clk);
        #1;
        chk("readback", {21'h0, w}, {21'h0, region_attribute_size_reg});
    endtask

    task automatic clr(input logic [7:0] m);
        cause_clear = m;
        @(posedge ref_clk);
        #1;
        cause_clear = 8'h00;
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Runs well under this; a hang ends here
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        mpu_enable = 1'b1;
        background_enable = 1'b0;
        attr_wr_en = 1'b0;
        attr_wr_region = 3'h0;
        attr_rd_region = 3'h0;
        attr_wr_data = 11'h000;
        cause_clear = 8'h00;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("cause", 32'h0, {24'h0, memmanage_fault_cause_reg});
        // Reserved code 100 is skipped: its behaviour is undefined
        for (int ap = 0; ap < 8; ap++) begin
            if (ap != 4) begin
                wr_attr(3'h0, {2'h2, ap[2:0], 6'h00});
                for (int k = 0; k < 4; k++) begin
                    core.access(32'h0000_1000, k[1], k[0], 1'b0, 8'h01, ok);
                    chk("grant", {31'h0, perm_ok[{ap[2:0], k[1:0]}]}, {31'h0, ok});
                end
            end
        end
        $display("permission test done");
        for (int i = 0; i < 12; i++) begin
            wr_attr(3'h2, {5'h13, dec_tab[i][12:7]});
            core.access(32'h0000_2000, 1'b0, 1'b0, 1'b0, 8'h04, ok);
            chk("type", {29'h0, dec_tab[i][6:4]}, {29'h0, acc_mem_type, acc_shareable});
            if (dec_tab[i][6:5] == 2'h2) begin
                chk("policy", {28'h0, dec_tab[i][3:0]}, {28'h0, inner_cache_policy, outer_cache_policy});
            end
        end
        $display("decode test done");
        wr_attr(3'h0, 11'h4c0);
        wr_attr(3'h5, 11'h400);
        wr_attr(3'h3, 11'h0c0);
        core.access(32'h0000_3000, 1'b1, 1'b0, 1'b0, 8'h21, ok);
        chk("grant", 32'h0, {31'h0, ok});
        chk("region", 32'hd, {28'h0, acc_region_valid, acc_region_num});
        core.access(32'h0000_3000, 1'b1, 1'b0, 1'b0, 8'h09, ok);
        chk("region", 32'h8, {28'h0, acc_region_valid, acc_region_num});
        mpu_enable = 1'b0;
        core.access(32'h0000_3000, 1'b0, 1'b1, 1'b0, 8'h20, ok);
        chk("grant", 32'h1, {31'h0, ok});
        core.access(32'h4000_0000, 1'b1, 1'b0, 1'b1, 8'h00, ok);
        chk("grant", 32'h0, {31'h0, ok});
        mpu_enable = 1'b1;
        // Region with execute-never set refuses fetches but not reads
        wr_attr(3'h1, 11'h6c0);
        core.access(32'h0000_3000, 1'b1, 1'b0, 1'b1, 8'h02, ok);
        chk("grant", 32'h0, {31'h0, ok});
        core.access(32'h0000_3000, 1'b1, 1'b0, 1'b0, 8'h02, ok);
        chk("grant", 32'h1, {31'h0, ok});
        $display("overlap test done");
        background_enable = 1'b1;
        core.access(32'h0000_4000, 1'b1, 1'b0, 1'b0, 8'h00, ok);
        chk("grant", 32'h1, {31'h0, ok});
        chk("type", 32'h4, {29'h0, acc_mem_type, acc_shareable});
        chk("policy", 32'ha, {28'h0, inner_cache_policy, outer_cache_policy});
        core.access(32'h0000_4000, 1'b0, 1'b0, 1'b0, 8'h00, ok);
        chk("grant", 32'h0, {31'h0, ok});
        background_enable = 1'b0;
        core.access(32'h0000_4000, 1'b1, 1'b0, 1'b0, 8'h00, ok);
        chk("grant", 32'h0, {31'h0, ok});
        $display("background test done");
        clr(8'hff);
        core.access(32'h0000_5004, 1'b1, 1'b0, 1'b1, 8'h20, ok);
        chk("cause", 32'h1, {24'h0, memmanage_fault_cause_reg});
        chk("fault addr", 32'h0000_5004, fault_addr);
        core.access(32'h0000_6008, 1'b0, 1'b1, 1'b0, 8'h20, ok);
        chk("cause", 32'h3, {24'h0, memmanage_fault_cause_reg});
        clr(8'h01);
        chk("cause", 32'h2, {24'h0, memmanage_fault_cause_reg});
        clr(8'h02);
        $display("cause test done");
        wrap_up();
    end
endmodule // tb_rapc_check
`default_nettype wire
